//--- rtl/eep_cmd_port.sv
// serial eeprom command port: link parser, command crossing, program engine
// assumes chip select, clock and data from an external master; sclk may stop
//
// Behaviour
// - chip select high selects; low deselects and enters standby
// - a started programming cycle finishes; standby only afterwards
// - chip select low keeps the frame logic in reset, clock ignored
// - bits sampled and shifted out on rising serial clock edges
// - serial clock may pause at either level anywhere
// - before a start bit, clock cycles change nothing
// - start bit is first rising edge with select and data in high
// - execute only after full count: 25 for write/write-all, else 9 (read starts output after 9)
// - after the last bit, clock and data ignored until new start
// - read is opcode 1 0, six address bits, then sixteen bits msb first
// - opcode 0 1 is word write with data, 1 1 is word erase
// - opcode 0 0 uses top address bits as sub-command, low four ignored
// - programming disabled at power-up until enable instruction runs
// - status shown when select rises again after low during programming
// - no status if select stays low or high throughout; else high-z
// - raising chip select leaves standby three system clock edges later
// - self-timed cycles need no serial clock
// - one zero bit before read data; release at next edge or select low
// - word write erases then programs, within 2 ms
// - word erase sets the word to all ones, within 1 ms
// - erase-all and write-all within 15 ms; write-all has no erase
`timescale 1ns/10ps
`default_nettype none
module eep_cmd_port #(
  parameter int WRITE_CYC = eep_pkg::WRITE_CYC,
  parameter int ERASE_CYC = eep_pkg::ERASE_CYC,
  parameter int ALL_CYC   = eep_pkg::ALL_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic chip_select,
  input  wire logic serial_data_in,
  output logic      serial_data_out,
  output logic      serial_data_out_oe_n,
  output logic      standby,
  output logic      prog_busy
);
  import eep_pkg::*;

  // ----------------------------------------------------------------
  // link side: parser and held command, serial clock domain
  // ----------------------------------------------------------------
  logic                link_rst_n;
  logic [ADDR_W-1:0]   rd_addr;
  logic [DATA_W-1:0]   rd_word;
  logic                cmd_fire;
  logic [1:0]          cmd_op;
  logic [ADDR_W-1:0]   cmd_addr;
  logic [DATA_W-1:0]   cmd_data;
  logic                rd_bit;
  logic                rd_drive;

  assign link_rst_n = rst_n & chip_select;

  typedef struct packed {
    logic              tog;
    logic [1:0]        op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eep_hold_t;

  typedef struct packed {
    logic              tog_m;
    logic              tog_s;
    logic              tog_seen;
    logic              cs_m;
    logic              cs_s;
    logic              busy;
    logic              enabled;
    eep_pgm_t          kind;
    logic [TMR_W-1:0]  tmr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              saw_low;
    logic              stat_en;
    logic              stby;
  } eep_eng_t;

  eep_hold_t hq;
  eep_hold_t hd;
  eep_eng_t  q;
  eep_eng_t  d;

  eep_link_rx u_rx (
    .sclk       (sclk),
    .link_rst_n (link_rst_n),
    .sdi        (serial_data_in),
    .pgm_busy   (q.busy),
    .rd_word    (rd_word),
    .rd_addr    (rd_addr),
    .cmd_fire   (cmd_fire),
    .cmd_op     (cmd_op),
    .cmd_addr   (cmd_addr),
    .cmd_data   (cmd_data),
    .rd_bit     (rd_bit),
    .rd_drive   (rd_drive)
  );

  // held across chip select low so the engine can still pick it up
  always_comb begin
    hd = hq;
    if (cmd_fire) begin
      hd.tog  = ~hq.tog;
      hd.op   = cmd_op;
      hd.addr = cmd_addr;
      hd.data = cmd_data;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hq <= '0;
    end else begin
      hq <= hd;
    end
  end

  // ----------------------------------------------------------------
  // program engine, system clock domain
  // ----------------------------------------------------------------
  logic              evt;
  logic              go;
  eep_pgm_t          go_kind;
  logic [TMR_W-1:0]  go_len;
  logic              mem_we;
  logic [DATA_W-1:0] mem [WORDS];

  assign evt = q.tog_s ^ q.tog_seen;

  always_comb begin
    d          = q;
    go         = 1'b0;
    go_kind    = PG_WORD;
    go_len     = '0;
    mem_we     = 1'b0;
    d.tog_m    = hq.tog;
    d.tog_s    = q.tog_m;
    d.tog_seen = q.tog_s;
    d.cs_m     = chip_select;
    d.cs_s     = q.cs_m;
    if (q.busy) begin
      if (q.tmr == '0) begin
        d.busy = 1'b0;
        mem_we = 1'b1;
      end else begin
        d.tmr = q.tmr - 1'b1;
      end
      if (!q.cs_s) begin
        d.saw_low = 1'b1;
      end
      if (q.cs_s && q.saw_low) begin
        d.stat_en = 1'b1;
      end
    end else if (evt) begin
      case (hq.op)
        OP_WRITE: begin
          go      = 1'b1;
          go_kind = PG_WORD;
          go_len  = TMR_W'(WRITE_CYC - 1);
        end
        OP_ERASE: begin
          go      = 1'b1;
          go_kind = PG_ERASE;
          go_len  = TMR_W'(ERASE_CYC - 1);
        end
        OP_EXT: begin
          case (hq.addr[ADDR_W-1 -: 2])
            SUB_ENABLE: begin
              d.enabled = 1'b1;
            end
            SUB_DISABLE: begin
              d.enabled = 1'b0;
            end
            SUB_ERASE_ALL: begin
              go      = 1'b1;
              go_kind = PG_ERASE_ALL;
              go_len  = TMR_W'(ALL_CYC - 1);
            end
            default: begin
              go      = 1'b1;
              go_kind = PG_WRITE_ALL;
              go_len  = TMR_W'(ALL_CYC - 1);
            end
          endcase
        end
        default: begin
          go = 1'b0;
        end
      endcase
      if (go && q.enabled) begin
        d.busy    = 1'b1;
        d.kind    = go_kind;
        d.tmr     = go_len;
        d.addr    = hq.addr;
        d.data    = hq.data;
        d.saw_low = 1'b0;
        d.stat_en = 1'b0;
      end
    end
    if (!q.cs_s) begin
      d.stat_en = 1'b0;
    end
    d.stby = !q.cs_s && !q.busy;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // cell array; read by the link only while no programming runs
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      case (q.kind)
        PG_WORD: begin
          mem[q.addr] <= q.data;
        end
        PG_ERASE: begin
          mem[q.addr] <= ERASED_WORD;
        end
        PG_ERASE_ALL: begin
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= ERASED_WORD;
          end
        end
        default: begin
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= mem[i] & q.data;
          end
        end
      endcase
    end
  end

  assign rd_word = mem[rd_addr];

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign serial_data_out      = rd_drive ? rd_bit : !q.busy;
  assign serial_data_out_oe_n = !(rd_drive || q.stat_en);
  assign standby              = q.stby;
  assign prog_busy            = q.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] busy_len;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= '0;
    end else if (q.busy) begin
      busy_len <= busy_len + 1'b1;
    end else begin
      busy_len <= '0;
    end
  end

  sequence s_cs_bounce;
    (q.busy && !q.cs_s) ##1 (q.busy && q.cs_s);
  endsequence

  property p_status_on;
    @(posedge mclk) disable iff (!rst_n)
    s_cs_bounce |=> (q.stat_en && !serial_data_out_oe_n);
  endproperty
  a_status_on: assert property (p_status_on)
    else $error("status not shown after select bounce");

  property p_status_cause;
    @(posedge mclk) disable iff (!rst_n)
    $rose(q.stat_en) |-> $past(q.saw_low);
  endproperty
  a_status_cause: assert property (p_status_cause)
    else $error("status shown without select low");

  property p_status_busy;
    @(posedge mclk) disable iff (!rst_n)
    (q.stat_en && q.busy) |-> (!serial_data_out && !serial_data_out_oe_n);
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("busy status not low");

  property p_needs_enable;
    @(posedge mclk) disable iff (!rst_n)
    $rose(q.busy) |-> $past(q.enabled);
  endproperty
  a_needs_enable: assert property (p_needs_enable)
    else $error("programming started while disabled");

  property p_no_new_cmd;
    @(posedge mclk) disable iff (!rst_n)
    (q.busy && evt && q.tmr != '0) |=> (q.busy && q.tmr == $past(q.tmr) - 1'b1);
  endproperty
  a_no_new_cmd: assert property (p_no_new_cmd)
    else $error("instruction taken while busy");

  property p_write_len;
    @(posedge mclk) disable iff (!rst_n)
    ($fell(q.busy) && q.kind == PG_WORD) |-> busy_len == TMR_W'(WRITE_CYC);
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("word write length wrong");

  property p_erase_word;
    @(posedge mclk) disable iff (!rst_n)
    ($fell(q.busy) && q.kind == PG_ERASE) |->
      (busy_len == TMR_W'(ERASE_CYC) && mem[q.addr] == ERASED_WORD);
  endproperty
  a_erase_word: assert property (p_erase_word)
    else $error("word erase wrong");

  property p_all_len;
    @(posedge mclk) disable iff (!rst_n)
    ($fell(q.busy) && (q.kind == PG_ERASE_ALL || q.kind == PG_WRITE_ALL)) |->
      busy_len == TMR_W'(ALL_CYC);
  endproperty
  a_all_len: assert property (p_all_len)
    else $error("chip-wide cycle length wrong");

  property p_standby_wait;
    @(posedge mclk) disable iff (!rst_n)
    (!q.cs_s && q.busy) |=> !standby;
  endproperty
  a_standby_wait: assert property (p_standby_wait)
    else $error("standby during programming");

  property p_dummy_zero;
    @(posedge sclk) disable iff (!link_rst_n)
    $rose(rd_drive) |-> !rd_bit;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero)
    else $error("read did not lead with zero");

  property p_fire_hold;
    @(posedge sclk) disable iff (!rst_n)
    cmd_fire |=> (hq.tog != $past(hq.tog) && hq.op == $past(cmd_op));
  endproperty
  a_fire_hold: assert property (p_fire_hold)
    else $error("finished instruction not held");
endmodule
`default_nettype wire

//--- rtl/eep_link_rx.sv
// serial frame parser running on the master's serial clock
// assumes link_rst_n is low whenever chip select is low
`timescale 1ns/10ps
`default_nettype none
module eep_link_rx (
  input  wire logic                        sclk,
  input  wire logic                        link_rst_n,
  input  wire logic                        sdi,
  input  wire logic                        pgm_busy,
  input  wire logic [eep_pkg::DATA_W-1:0]  rd_word,
  output logic      [eep_pkg::ADDR_W-1:0]  rd_addr,
  output logic                             cmd_fire,
  output logic      [1:0]                  cmd_op,
  output logic      [eep_pkg::ADDR_W-1:0]  cmd_addr,
  output logic      [eep_pkg::DATA_W-1:0]  cmd_data,
  output logic                             rd_bit,
  output logic                             rd_drive
);
  import eep_pkg::*;

  typedef struct packed {
    eep_link_t             st;
    logic [CNT_W-1:0]      cnt;
    logic [HEAD_BITS-1:0]  head;
    logic [DATA_W-1:0]     sh;
    logic                  sdo;
    logic                  oe;
    logic                  busy_m;
    logic                  busy_s;
  } eep_rx_t;

  eep_rx_t              q;
  eep_rx_t              d;
  logic [HEAD_BITS-1:0] head_nx;
  logic [HEAD_BITS-1:0] head_sel;
  logic                 fire;

  assign head_nx  = {q.head[HEAD_BITS-2:0], sdi};
  assign head_sel = (q.st == LK_DIN) ? q.head : head_nx;
  assign rd_addr  = head_nx[ADDR_W-1:0];
  assign cmd_op   = eep_op(head_sel);
  assign cmd_addr = head_sel[ADDR_W-1:0];
  assign cmd_data = (q.st == LK_DIN) ? {q.sh[DATA_W-2:0], sdi} : '0;
  assign cmd_fire = fire;
  assign rd_bit   = q.sdo;
  assign rd_drive = q.oe;

  // ----------------------------------------------------------------
  // frame sequencing, one step per rising serial clock edge
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    fire     = 1'b0;
    d.busy_m = pgm_busy;
    d.busy_s = q.busy_m;
    case (q.st)
      LK_IDLE: begin
        if (sdi) begin
          d.st  = LK_HEAD;
          d.cnt = '0;
        end
      end
      LK_HEAD: begin
        d.head = head_nx;
        d.cnt  = q.cnt + 1'b1;
        if (q.cnt == HEAD_LAST) begin
          d.cnt = '0;
          d.st  = LK_DONE;
          if (eep_op(head_nx) == OP_READ) begin
            if (!q.busy_s) begin
              d.st  = LK_DOUT;
              d.sh  = rd_word;
              d.sdo = 1'b0;
              d.oe  = 1'b1;
            end
          end else if (eep_op(head_nx) == OP_WRITE ||
                       (eep_op(head_nx) == OP_EXT && eep_sub(head_nx) == SUB_WRITE_ALL)) begin
            d.st = LK_DIN;
          end else begin
            fire = 1'b1;
          end
        end
      end
      LK_DIN: begin
        d.sh  = {q.sh[DATA_W-2:0], sdi};
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == DATA_LAST) begin
          fire = 1'b1;
          d.st = LK_DONE;
        end
      end
      LK_DOUT: begin
        if (q.cnt == DOUT_END) begin
          d.oe = 1'b0;
          d.st = LK_DONE;
        end else begin
          d.sdo = q.sh[DATA_W-1];
          d.sh  = {q.sh[DATA_W-2:0], 1'b0};
          d.cnt = q.cnt + 1'b1;
        end
      end
      default: begin
        d.st = LK_DONE;
      end
    endcase
  end

  // state moves only on clock edges and on link reset, so pauses are harmless
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/eep_pkg.sv
// constants, encodings and state types of the serial eeprom command port
// assumes a 10 MHz system clock; the link clock is the master's serial clock
package eep_pkg;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 16;
  localparam int WORDS     = 64;
  localparam int HEAD_BITS = 8;
  localparam int CNT_W     = 5;
  localparam int TMR_W     = 18;

  // bit counts inside a frame, counted from zero
  localparam logic [CNT_W-1:0] HEAD_LAST = 5'h07;
  localparam logic [CNT_W-1:0] DATA_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] DOUT_END  = 5'h10;

  localparam logic [1:0] OP_EXT        = 2'h0;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_ERASE      = 2'h3;
  localparam logic [1:0] SUB_DISABLE   = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE    = 2'h3;

  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  localparam int MCLK_MHZ      = 10;
  localparam int WRITE_TIME_US = 2000;
  localparam int ERASE_TIME_US = 1000;
  localparam int ALL_TIME_US   = 15000;
  // longest times, rounded down to whole cycles
  localparam int WRITE_CYC = WRITE_TIME_US * MCLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * MCLK_MHZ;
  localparam int ALL_CYC   = ALL_TIME_US * MCLK_MHZ;

  typedef enum logic [2:0] {LK_IDLE, LK_HEAD, LK_DIN, LK_DOUT, LK_DONE} eep_link_t;
  typedef enum logic [1:0] {PG_WORD, PG_ERASE, PG_ERASE_ALL, PG_WRITE_ALL} eep_pgm_t;

  // opcode field and sub-command field of the eight header bits
  function automatic logic [1:0] eep_op(input logic [HEAD_BITS-1:0] h);
    return h[HEAD_BITS-1 -: 2];
  endfunction
  function automatic logic [1:0] eep_sub(input logic [HEAD_BITS-1:0] h);
    return h[ADDR_W-1 -: 2];
  endfunction
endpackage

//--- rtl/placeholder_none.sv
// intentionally empty compile unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- verif/eep_cmd_port_test.sv
// self-checking bench of the serial eeprom command port
// assumes eep_master drives the link; programming times shortened
`timescale 1ns/10ps
`default_nettype none
module eep_cmd_port_test;
  import eep_pkg::*;
  localparam int WC = 20;
  localparam int EC = 10;
  localparam int AC = 40;
  logic        mclk;
  logic        rst_n;
  logic        sclk;
  logic        cs;
  logic        sdi;
  logic        sdo;
  logic        oe_n;
  logic        standby;
  logic        prog_busy;
  logic [16:0] rd;
  logic        oe;
  int          n_errors = 0;
  int          total_checks = 0;

  eep_cmd_port #(.WRITE_CYC(WC), .ERASE_CYC(EC), .ALL_CYC(AC)) i_eep_cmd_port (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .chip_select(cs),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe_n(oe_n),
    .standby(standby), .prog_busy(prog_busy));
  eep_master i_eep_master (
    .sclk(sclk), .chip_select(cs), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_oe_n(oe_n));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                     input int n);
    logic [24:0] b;
    b = {1'b1, op, a, d};
    i_eep_master.frame(n, (n == 25) ? b : b >> 16, 0, rd, oe);
  endtask
  task automatic rdw(input logic [5:0] a, input logic [15:0] e);
    i_eep_master.frame(9, {16'h0000, 1'b1, OP_READ, a}, 17, rd, oe);
    check(rd, {1'b0, e});
    check(oe, 1'b1);
  endtask
  // counts busy cycles of the next programming run
  task automatic wait_prog(input int n);
    int c = 0;
    for (int i = 0; i < n + 20; i++) begin
      @(negedge mclk);
      if (prog_busy === 1'b1) c++;
      else if (c > 0) break;
    end
    check(c, n);
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 100 && prog_busy !== v; i++) @(negedge mclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_disabled;
    check({prog_busy, oe_n, standby}, 3'h3);
    cmd(OP_WRITE, 6'h03, 16'h1234, 25);
    wait_prog(0);
    cmd(OP_ERASE, 6'h03, 16'h0000, 9);
    wait_prog(0);
    $display("disabled done");
  endtask
  task automatic t_enable;
    cmd(OP_EXT, {SUB_ENABLE, 4'hA}, 16'h0000, 9);
    wait_prog(0);
    cmd(OP_EXT, {SUB_ERASE_ALL, 4'h5}, 16'h0000, 9);
    wait_prog(AC);
    rdw(6'h00, 16'hFFFF);
    rdw(6'h3F, 16'hFFFF);
    $display("enable done");
  endtask
  task automatic t_write;
    cmd(OP_WRITE, 6'h05, 16'h1234, 25);
    wait_prog(WC);
    cmd(OP_WRITE, 6'h06, 16'h8001, 25);
    wait_prog(WC);
    i_eep_master.hold = 1000;
    rdw(6'h05, 16'h1234);
    i_eep_master.hold = 0;
    rdw(6'h06, 16'h8001);
    cmd(OP_ERASE, 6'h05, 16'h0000, 9);
    wait_prog(EC);
    rdw(6'h05, 16'hFFFF);
    i_eep_master.frame(24, 25'({1'b1, OP_WRITE, 6'h06, 15'h0000}), 0, rd, oe);
    wait_prog(0);
    rdw(6'h06, 16'h8001);
    $display("write done");
  endtask
  task automatic t_status;
    cmd(OP_WRITE, 6'h07, 16'h00FF, 25);
    wait_busy(1'b1);
    check({prog_busy, oe_n, standby}, 3'h6);
    i_eep_master.sel(1'b1);
    repeat (5) @(negedge mclk);
    check({oe_n, sdo, standby}, 3'h0);
    wait_busy(1'b0);
    repeat (5) @(negedge mclk);
    check({oe_n, sdo}, 2'h1);
    i_eep_master.sel(1'b0);
    repeat (5) @(negedge mclk);
    check({oe_n, standby}, 2'h3);
    i_eep_master.keep = 1;
    cmd(OP_WRITE, 6'h09, 16'h3C3C, 25);
    wait_busy(1'b1);
    check({prog_busy, oe_n, standby}, 3'h6);
    wait_busy(1'b0);
    repeat (5) @(negedge mclk);
    check({oe_n, standby}, 2'h2);
    i_eep_master.keep = 0;
    i_eep_master.sel(1'b0);
    rdw(6'h09, 16'h3C3C);
    $display("status done");
  endtask
  task automatic t_busy;
    cmd(OP_WRITE, 6'h08, 16'h0F0F, 25);
    cmd(OP_ERASE, 6'h08, 16'h0000, 9);
    @(negedge mclk);
    check(prog_busy, 1'b1);
    check(standby, 1'b0);
    wait_busy(1'b0);
    wait_prog(0);
    rdw(6'h08, 16'h0F0F);
    $display("busy done");
  endtask
  task automatic t_all;
    cmd(OP_EXT, {SUB_WRITE_ALL, 4'h0}, 16'hA5A5, 25);
    wait_prog(AC);
    rdw(6'h05, 16'hA5A5);
    rdw(6'h07, 16'h00A5);
    cmd(OP_EXT, {SUB_DISABLE, 4'hF}, 16'h0000, 9);
    wait_prog(0);
    cmd(OP_WRITE, 6'h05, 16'h0000, 25);
    wait_prog(0);
    rdw(6'h05, 16'hA5A5);
    $display("all done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    t_disabled;
    t_enable;
    t_write;
    t_status;
    t_busy;
    t_all;
    stop_test;
  end
  initial begin
    #2000000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire

//--- verif/eep_master.sv
// serial master model: select, clock and data in, framed per instruction
// assumes the port samples data in on rising sclk; sclk rests low
`timescale 1ns/10ps
`default_nettype none
module eep_master (
  output logic      sclk,
  output logic      chip_select,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe_n
);
  int hold = 0;
  // keep set: select stays high after the last clock of a frame
  int keep = 0;
  initial begin
    sclk = 1'b0;
    chip_select = 1'b0;
    serial_data_in = 1'b0;
  end
  // ----------------------------------------
  // link tasks
  // ----------------------------------------
  task automatic sel(input logic v);
    chip_select = v;
  endtask
  // one clock; hold stretches the high phase
  task automatic tick(input logic d);
    serial_data_in = d;
    #62.5 sclk = 1'b1;
    #(62.5 + hold) sclk = 1'b0;
  endtask
  // n bits msb first, then x clocks capturing dummy and read data
  task automatic frame(input int n, input logic [24:0] b, input int x,
                       output logic [16:0] rd, output logic oe);
    rd = '0;
    oe = 1'b1;
    #150 chip_select = 1'b1;
    tick(1'b0);
    tick(1'b0);
    for (int i = n - 1; i >= 0; i--) tick(b[i]);
    if (x > 0) rd = {rd[15:0], serial_data_out};
    for (int j = 0; j < x; j++) begin
      tick(~serial_data_in);
      if (j < x - 1) rd = {rd[15:0], serial_data_out};
      else oe = serial_data_out_oe_n;
    end
    if (keep == 0) begin
      chip_select = 1'b0;
    end
    serial_data_in = ~serial_data_in;
  endtask
endmodule
`default_nettype wire
